/* rtl/qrxc_top.sv */
// qrxc_top: receive control two and transmit queue free space registers with their datapath hooks
// assumes a synchronous 16-bit register port on core_clk; host writes and reads whole words
`timescale 1ns/1ps
module qrxc_top #(
   parameter int          PAUSE_CYCLES = qrxc_pkg::PAUSE_CYCLES,
   parameter logic [12:0] TXQ_BYTES    = qrxc_pkg::FREE_RESET
) (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic [8:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   input  wire logic [47:0] station_addr,
   input  wire logic        rxq_above_low,
   input  wire logic        rxq_near_high,
   input  wire logic        pause_ack,
   output logic             pause_req,
   output logic             pause_timer_running,
   input  wire logic        frame_done,
   input  wire logic [47:0] frame_src_addr,
   input  wire logic        is_ipv6_udp_frag,
   input  wire logic        is_udp_lite,
   input  wire logic        is_icmp,
   input  wire logic        is_ip_fragment,
   input  wire logic        csum_bad,
   output logic             frame_drop,
   output logic             frame_verdict,
   output logic             tx_udp_lite_gen,
   input  wire logic        txq_wr_byte,
   input  wire logic        txq_frame_start,
   input  wire logic        tx_release,
   input  wire logic [12:0] tx_release_bytes
);
   initial if (TXQ_BYTES == 13'h0000) $error("transmit queue size must be nonzero");

   logic [15:0] rx_ctrl_two_r;
   logic [12:0] free_bytes_r;
   logic [14:0] free_calc;

   // register writes, reserved bits stay at their constant values
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         rx_ctrl_two_r <= qrxc_pkg::RX_CTRL_TWO_RESET;
      else if (reg_wr && reg_addr == qrxc_pkg::ADDR_RX_CTRL_TWO)
         rx_ctrl_two_r <= reg_wdata & qrxc_pkg::RX_CTRL_TWO_WMASK;
   end

   // free space: release adds back, host bytes and control word subtract
   // two spare bits: bit 14 flags underflow, bit 13 a large release sum
   always_comb
   begin
      free_calc = {2'b00, free_bytes_r};
      if (tx_release)
         free_calc = free_calc + {2'b00, tx_release_bytes};
      if (txq_wr_byte)
         free_calc = free_calc - 15'h0001;
      if (txq_frame_start)
         free_calc = free_calc - {2'b00, qrxc_pkg::CTRL_WORD_BYTES};
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         free_bytes_r <= qrxc_pkg::FREE_RESET;
      else if (free_calc[14])
         free_bytes_r <= 13'h0000;
      else if (free_calc[13:0] > {1'b0, TXQ_BYTES})
         free_bytes_r <= TXQ_BYTES;
      else
         free_bytes_r <= free_calc[12:0];
   end

   // read mux: unmapped and reserved addresses read zero
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         reg_rdata <= 16'h0000;
      else if (reg_rd && reg_addr == qrxc_pkg::ADDR_RX_CTRL_TWO)
         reg_rdata <= rx_ctrl_two_r;
      else if (reg_rd && reg_addr == qrxc_pkg::ADDR_TXQ_FREE)
         reg_rdata <= {3'h0, free_bytes_r};
      else
         reg_rdata <= 16'h0000;
   end

   assign tx_udp_lite_gen = rx_ctrl_two_r[qrxc_pkg::BIT_UDP_LITE_EN];

   qrxc_pause #(
      .PAUSE_CYCLES (PAUSE_CYCLES)
   ) u_pause (
      .core_clk           (core_clk),
      .rstn               (rstn),
      .pause_timer_enable (rx_ctrl_two_r[qrxc_pkg::BIT_PAUSE_TMR_EN]),
      .rxq_above_low      (rxq_above_low),
      .rxq_near_high      (rxq_near_high),
      .pause_ack          (pause_ack),
      .pause_req          (pause_req),
      .timer_running      (pause_timer_running)
   );

   qrxc_filter u_filter (
      .core_clk         (core_clk),
      .rstn             (rstn),
      .frag_pass        (rx_ctrl_two_r[qrxc_pkg::BIT_FRAG_PASS]),
      .udp_lite_en      (rx_ctrl_two_r[qrxc_pkg::BIT_UDP_LITE_EN]),
      .icmp_check       (rx_ctrl_two_r[qrxc_pkg::BIT_ICMP_CHECK]),
      .src_filter       (rx_ctrl_two_r[qrxc_pkg::BIT_SRC_FILTER]),
      .station_addr     (station_addr),
      .frame_done       (frame_done),
      .frame_src_addr   (frame_src_addr),
      .is_ipv6_udp_frag (is_ipv6_udp_frag),
      .is_udp_lite      (is_udp_lite),
      .is_icmp          (is_icmp),
      .is_ip_fragment   (is_ip_fragment),
      .csum_bad         (csum_bad),
      .frame_drop       (frame_drop),
      .frame_verdict    (frame_verdict)
   );

   reset_val_a: assert property (@(posedge core_clk)
      $rose(rstn) |-> rx_ctrl_two_r == qrxc_pkg::RX_CTRL_TWO_RESET && free_bytes_r == qrxc_pkg::FREE_RESET)
      else $error("wrong reset value");
   free_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
      txq_wr_byte && !txq_frame_start && !tx_release && free_bytes_r != 13'h0000 |=>
      free_bytes_r == $past(free_bytes_r) - 13'h0001)
      else $error("free space not reduced by a written byte");
   ctrl_word_a: assert property (@(posedge core_clk) disable iff (!rstn)
      txq_frame_start && !txq_wr_byte && !tx_release && free_bytes_r >= qrxc_pkg::CTRL_WORD_BYTES |=>
      free_bytes_r == $past(free_bytes_r) - qrxc_pkg::CTRL_WORD_BYTES)
      else $error("control word not accounted");
   free_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_rd && reg_addr == qrxc_pkg::ADDR_TXQ_FREE |=> reg_rdata == {3'h0, $past(free_bytes_r)})
      else $error("free space read mismatch");
   wr_read_c: cover property (@(posedge core_clk) disable iff (!rstn)
      reg_wr && reg_addr == qrxc_pkg::ADDR_RX_CTRL_TWO ##1 reg_rd && reg_addr == qrxc_pkg::ADDR_RX_CTRL_TWO);
   release_c: cover property (@(posedge core_clk) disable iff (!rstn) tx_release);
endmodule

/* rtl/qrxc_pkg.sv */
// qrxc_pkg: constants for the receive control two / transmit queue free space block
// assumes a 16-bit register port with byte addresses and word-aligned accesses
package qrxc_pkg;
   localparam logic [8:0]  ADDR_RX_CTRL_TWO   = 9'h176;
   localparam logic [8:0]  ADDR_TXQ_FREE      = 9'h178;
   localparam logic [8:0]  ADDR_RSVD_GAP      = 9'h17a;
   localparam int          BIT_PAUSE_TMR_EN   = 8;
   localparam int          BIT_FRAG_PASS      = 4;
   localparam int          BIT_UDP_LITE_EN    = 2;
   localparam int          BIT_ICMP_CHECK     = 1;
   localparam int          BIT_SRC_FILTER     = 0;
   localparam logic [15:0] RX_CTRL_TWO_WMASK  = 16'h0117;
   localparam logic [15:0] RX_CTRL_TWO_RESET  = 16'h0114;
   localparam int          FREE_W             = 13;
   localparam logic [12:0] FREE_RESET         = 13'h1800;
   localparam logic [12:0] CTRL_WORD_BYTES    = 13'h0004;
   localparam int          PAUSE_TIME_NS      = 655360;
   localparam int          CLK_PERIOD_NS      = 10;
   localparam int          PAUSE_CYCLES       = PAUSE_TIME_NS / CLK_PERIOD_NS;
   typedef enum logic [1:0] {
      QRXC_P_IDLE  = 2'b00,
      QRXC_P_SEND  = 2'b01,
      QRXC_P_TIMER = 2'b10
   } qrxc_pause_t;
endpackage

/* rtl/qrxc_pause.sv */
// qrxc_pause: pause frame sequencing driven by receive queue water marks
// assumes the water mark flags are produced by logic on core_clk
`timescale 1ns/1ps
module qrxc_pause #(
   parameter int PAUSE_CYCLES = qrxc_pkg::PAUSE_CYCLES
) (
   input  wire logic core_clk,
   input  wire logic rstn,
   input  wire logic pause_timer_enable,
   input  wire logic rxq_above_low,
   input  wire logic rxq_near_high,
   input  wire logic pause_ack,
   output logic      pause_req,
   output logic      timer_running
);
   initial if (PAUSE_CYCLES < 2) $error("pause cycles too small");
   qrxc_pkg::qrxc_pause_t state_r;
   logic [31:0]           cnt_r;
   wire                   expired = (cnt_r == 32'h0000_0000);

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r <= qrxc_pkg::QRXC_P_IDLE;
         cnt_r   <= 32'h0000_0000;
      end
      else
      begin
         case (state_r)
            qrxc_pkg::QRXC_P_IDLE:
               if (rxq_near_high)
                  state_r <= qrxc_pkg::QRXC_P_SEND;
            qrxc_pkg::QRXC_P_SEND:
               if (pause_ack)
               begin
                  state_r <= pause_timer_enable ? qrxc_pkg::QRXC_P_TIMER : qrxc_pkg::QRXC_P_IDLE;
                  cnt_r   <= 32'(PAUSE_CYCLES - 1);
               end
            qrxc_pkg::QRXC_P_TIMER:
               if (!rxq_above_low || !pause_timer_enable)
                  state_r <= qrxc_pkg::QRXC_P_IDLE;
               else if (expired)
                  state_r <= qrxc_pkg::QRXC_P_SEND;
               else
                  cnt_r <= cnt_r - 32'h0000_0001;
            default:
               state_r <= qrxc_pkg::QRXC_P_IDLE;
         endcase
      end
   end

   assign pause_req     = (state_r == qrxc_pkg::QRXC_P_SEND);
   assign timer_running = (state_r == qrxc_pkg::QRXC_P_TIMER);

   timer_stop_a: assert property (@(posedge core_clk) disable iff (!rstn)
      timer_running && !rxq_above_low |=> !timer_running)
      else $error("pause timer kept running below low mark");
   resend_a: assert property (@(posedge core_clk) disable iff (!rstn)
      timer_running && expired && rxq_above_low && pause_timer_enable |=> pause_req)
      else $error("no further pause after expiry");
   high_send_a: assert property (@(posedge core_clk) disable iff (!rstn)
      state_r == qrxc_pkg::QRXC_P_IDLE && rxq_near_high |=> pause_req)
      else $error("pause not requested near high mark");
   resend_c: cover property (@(posedge core_clk) disable iff (!rstn) timer_running ##1 pause_req);
endmodule

/* rtl/qrxc_filter.sv */
// qrxc_filter: per-frame keep/drop and checksum decisions from receive control two
// assumes frame attributes are valid on the cycle frame_done pulses
`timescale 1ns/1ps
module qrxc_filter (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic        frag_pass,
   input  wire logic        udp_lite_en,
   input  wire logic        icmp_check,
   input  wire logic        src_filter,
   input  wire logic [47:0] station_addr,
   input  wire logic        frame_done,
   input  wire logic [47:0] frame_src_addr,
   input  wire logic        is_ipv6_udp_frag,
   input  wire logic        is_udp_lite,
   input  wire logic        is_icmp,
   input  wire logic        is_ip_fragment,
   input  wire logic        csum_bad,
   output logic             frame_drop,
   output logic             frame_verdict
);
   logic csum_ignored;
   logic drop_nxt;

   always_comb
   begin
      csum_ignored = (is_ipv6_udp_frag && frag_pass)
                   || (is_udp_lite && !udp_lite_en);
      drop_nxt = 1'b0;
      if (src_filter && frame_src_addr == station_addr)
         drop_nxt = 1'b1;
      else if (is_icmp && !is_ip_fragment)
         drop_nxt = icmp_check && csum_bad;
      else if (is_udp_lite)
         drop_nxt = udp_lite_en && csum_bad;
      else if (!csum_ignored)
         drop_nxt = 1'b0;
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         frame_drop    <= 1'b0;
         frame_verdict <= 1'b0;
      end
      else
      begin
         frame_verdict <= frame_done;
         frame_drop    <= frame_done & drop_nxt;
      end
   end

   src_drop_a: assert property (@(posedge core_clk) disable iff (!rstn)
      frame_done && src_filter && frame_src_addr == station_addr |=> frame_verdict && frame_drop)
      else $error("own source frame not dropped");
   icmp_keep_a: assert property (@(posedge core_clk) disable iff (!rstn)
      frame_done && is_icmp && !icmp_check && !src_filter |=> !frame_drop)
      else $error("icmp frame dropped with check off");
   frag_pass_a: assert property (@(posedge core_clk) disable iff (!rstn)
      frame_done && is_ipv6_udp_frag && frag_pass && !is_udp_lite && !is_icmp && !src_filter |=> !frame_drop)
      else $error("ipv6 udp fragment dropped");
   lite_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
      frame_done && is_udp_lite && !udp_lite_en && !is_icmp && !src_filter |=> !frame_drop)
      else $error("udp lite checked while disabled");
   icmp_drop_c: cover property (@(posedge core_clk) disable iff (!rstn) frame_done && is_icmp ##1 frame_drop);
endmodule

/* dv/qrxc_mac_model.sv */
// qrxc_mac_model: mac transmit side that answers pause requests after a delay
// assumes pause_req is a level held until pause_ack is seen
`timescale 1ns/1ps
module qrxc_mac_model (
   input  wire logic       core_clk,
   input  wire logic       rstn,
   input  wire logic       pause_req,
   input  wire logic [1:0] delay,
   output logic            pause_ack,
   output int              acks
);
   int wait_c;
   always @(negedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pause_ack <= 1'b0;
         wait_c <= 0;
         acks <= 0;
      end
      else if (pause_ack)
         pause_ack <= 1'b0;
      else if (pause_req && wait_c >= delay)
      begin
         pause_ack <= 1'b1;
         wait_c <= 0;
         acks <= acks + 1;
      end
      else if (pause_req)
         wait_c <= wait_c + 1;
   end
endmodule

/* dv/testbench.sv */
// testbench: registers, frame verdicts, free space and pause sequencing of qrxc_top
// assumes the mac model answers pauses; results are checked in order from queues
`timescale 1ns/1ps
module testbench;
   logic        core_clk, rstn, reg_wr, reg_rd, rxq_above_low, rxq_near_high, pause_ack, pause_req, running;
   logic        frame_done, frag, lite, icmp, ipf, bad, frame_drop, frame_verdict, lite_gen, wr_b, f_start, rel, rd_p;
   logic [8:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, ctl;
   logic [47:0] sta, src;
   logic [12:0] rel_bytes;
   logic [1:0]  delay;
   logic [15:0] exp_rd[$];
   logic        exp_fr[$];
   int          seed = 32'h8dbf, bad_count, comparisons, acks, k;
   qrxc_top #(.PAUSE_CYCLES(8)) uut (
      .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .station_addr(sta), .rxq_above_low(rxq_above_low),
      .rxq_near_high(rxq_near_high), .pause_ack(pause_ack), .pause_req(pause_req), .pause_timer_running(running),
      .frame_done(frame_done), .frame_src_addr(src), .is_ipv6_udp_frag(frag), .is_udp_lite(lite), .is_icmp(icmp),
      .is_ip_fragment(ipf), .csum_bad(bad), .frame_drop(frame_drop), .frame_verdict(frame_verdict),
      .tx_udp_lite_gen(lite_gen), .txq_wr_byte(wr_b), .txq_frame_start(f_start), .tx_release(rel),
      .tx_release_bytes(rel_bytes));
   qrxc_mac_model mac (.core_clk(core_clk), .rstn(rstn), .pause_req(pause_req), .delay(delay),
      .pause_ack(pause_ack), .acks(acks));
   task automatic cmp_rd(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_rd({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic report_and_stop;
      $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [8:0] a, input logic [15:0] e);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      exp_rd.push_back(e);
      @(negedge core_clk);
      reg_rd = 1'b0;
   endtask
   task automatic frame();
      @(negedge core_clk);
      src = ($random(seed) & 1) ? sta : 48'({$random(seed), $random(seed)});
      {frag, lite, icmp, ipf, bad} = 5'($random(seed));
      // a frame has one transport type only
      lite = lite & !frag;
      icmp = icmp & !frag & !lite;
      exp_fr.push_back(ctl[0] && src == sta ? 1'b1 : icmp && !ipf ? ctl[1] & bad : lite & ctl[2] & bad);
      frame_done = 1'b1;
      @(negedge core_clk);
      frame_done = 1'b0;
   endtask
   task automatic wait_acks(input int n);
      for (int i = 0; i < 100 && acks < n; i++)
         @(negedge core_clk);
   endtask
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
      rd_p <= reg_rd;
   always @(negedge core_clk)
   begin
      if (rd_p === 1'b1)
         cmp_rd(reg_rdata, exp_rd.pop_front());
      if (frame_verdict === 1'b1)
         cmp_bit(frame_drop, exp_fr.pop_front());
   end
   initial
   begin
      repeat (5000) @(posedge core_clk);
      bad_count++;
      report_and_stop;
   end
   initial
   begin
      {rstn, reg_wr, reg_rd, rxq_above_low, rxq_near_high, frame_done, wr_b, f_start, rel} = '0;
      {reg_addr, reg_wdata, rel_bytes, src, frag, lite, icmp, ipf, bad} = '0;
      sta = 48'({$random(seed), $random(seed)});
      delay = 2'($random(seed));
      repeat (16) @(negedge core_clk);
      rstn = 1'b1;
      rd(9'h176, 16'h0114);
      cmp_bit(lite_gen, 1'b1);
      rd(9'h178, 16'h1800);
      wr(9'h178, 16'h0000);
      wr(9'h17a, 16'hffff);
      rd(9'h178, 16'h1800);
      rd(9'h17a, 16'h0000);
      wr(9'h176, 16'hffff);
      rd(9'h176, 16'h0117);
      for (k = 0; k < 128; k++)
      begin
         ctl = 16'($random(seed)) & 16'h0107 | 16'h0010;
         wr(9'h176, ctl);
         cmp_bit(lite_gen, ctl[2]);
         frame();
      end
      k = $unsigned($random(seed)) % 64 + 1;
      rd(9'h178, 16'h1800);
      @(negedge core_clk);
      wr_b = 1'b1;
      f_start = 1'b1;
      @(negedge core_clk);
      f_start = 1'b0;
      repeat (k - 1) @(negedge core_clk);
      wr_b = 1'b0;
      rd(9'h178, 16'h1800 - 16'(k) - 16'h0004);
      rel_bytes = 13'(k + 4);
      rel = 1'b1;
      @(negedge core_clk);
      rel = 1'b0;
      rd(9'h178, 16'h1800);
      wr(9'h176, 16'h0114);
      rxq_above_low = 1'b1;
      rxq_near_high = 1'b1;
      @(negedge core_clk);
      rxq_near_high = 1'b0;
      cmp_bit(pause_req, 1'b1);
      wait_acks(1);
      repeat (2) @(negedge core_clk);
      cmp_bit(running, 1'b1);
      wait_acks(2);
      cmp_bit(acks == 2, 1'b1);
      rxq_above_low = 1'b0;
      repeat (30) @(negedge core_clk);
      cmp_bit(running | pause_req, 1'b0);
      k = acks;
      repeat (30) @(negedge core_clk);
      cmp_bit(acks == k, 1'b1);
      wr(9'h176, 16'h0014);
      rxq_above_low = 1'b1;
      rxq_near_high = 1'b1;
      @(negedge core_clk);
      rxq_near_high = 1'b0;
      repeat (40) @(negedge core_clk);
      cmp_bit(acks == k + 1 && !running, 1'b1);
      cmp_bit(exp_rd.size() == 0 && exp_fr.size() == 0, 1'b1);
      report_and_stop;
   end
endmodule
